// ### design/dq_pkg.sv
// Summary of operation
// - eight general lines, each set by the host as input or output
// - an input line reads 1 when driven high and 0 when low
// - event input feeds a host-readable 32-bit counter
// - counter advances by one on rising edges only, never on falling edges
// - counter keeps up with event input rates up to 1 MHz
// - pacing input: each external rising edge paces one conversion, max 50 kHz
// - pacing pin as output carries the internal conversion pacer clock
// - after defaults the pacing pin stays an input until output is enabled
// - trigger starts acquisition on a host-selected rising or falling edge
// - every analog channel keeps its own input range setting
// - gain entries hold channel and one of four bipolar range codes on-board
// - results are offset binary, zero volts gives mid-scale code 32768
// - inputs beyond the range saturate to full-scale codes, never wrap
// - master drives pacer out, slave paces from pin with external option
// - after power-on or reset all general lines are inputs
// - burst mode captures samples into a 32 K sample on-board buffer
package dq_pkg;

    // clock and pacing-pin timing
    localparam int CLK_FREQ_KHZ = 50000;
    localparam int EXT_PACE_MAX_KHZ = 50;
    // least period of the external pace, rounded up to whole cycles
    localparam logic [10:0] EXT_PACE_MIN_CYC =
        11'((CLK_FREQ_KHZ + EXT_PACE_MAX_KHZ - 1) / EXT_PACE_MAX_KHZ);

    localparam int NUM_LINES = 8;
    localparam int GQ_DEPTH = 8;
    localparam int GQ_AW = 3;
    localparam int BUF_DEPTH = 32768;
    localparam int BUF_AW = 15;
    localparam logic [15:0] BUF_FULL_LVL = 16'h8000;

    // reset values
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] DOUT_RST = 8'h00;
    localparam logic [15:0] PACER_DIV_RST = 16'h03E8;
    localparam logic [15:0] PACER_DIV_MIN = 16'h0002;

    // result codes
    localparam logic [15:0] CODE_MID = 16'h8000;
    localparam logic [15:0] CODE_FULL = 16'hFFFF;
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic signed [17:0] SAMPLE_MAX = 18'sh07FFF;
    localparam logic signed [17:0] SAMPLE_MIN = -18'sh08000;

    // synchroniser lane positions
    localparam int SY_EV = 8;
    localparam int SY_TRIG = 9;
    localparam int SY_PACE = 10;
    localparam int SY_W = 11;

    typedef enum logic [1:0] {
        bipolar_ten_volt_range = 2'h0,
        bipolar_five_volt_range = 2'h1,
        bipolar_two_volt_range = 2'h2,
        bipolar_one_volt_range = 2'h3
    } dq_range_t;

    typedef enum logic [2:0] {
        ACQ_IDLE = 3'h1,
        ACQ_ARMED = 3'h2,
        ACQ_RUN = 3'h4
    } dq_acq_t;

    typedef struct packed {
        logic [2:0] chan;
        dq_range_t range;
    } dq_gq_t;

    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] dout;
        logic pace_out;
        logic external_pacing_option;
        logic trig_rise;
        logic trig_en;
        logic burst;
        logic [15:0] pdiv;
    } dq_cfg_t;

    typedef struct packed {
        dq_cfg_t cfg;
        dq_acq_t acq;
        logic prev_ev;
        logic prev_trig;
        logic prev_pace;
        logic [31:0] ctr;
        logic [15:0] pcnt;
        logic plvl;
        logic [2:0] gq_idx;
        logic [7:0] din;
        logic conv;
        dq_gq_t conv_e;
        logic res_v;
        logic [15:0] res;
        logic [15:0] wr_ptr;
        logic [15:0] rd_ptr;
        logic rd_v;
        logic [10:0] gap;
        logic ovr;
    } dq_state_t;

endpackage : dq_pkg

// ### design/dq_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser; only the second stage is visible outside
module dq_sync
    import dq_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;

    // pins settle for a full cycle before any logic looks at them
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_ff <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule : dq_sync

// ### design/dq_mem.sv
`timescale 1ns/1ns
// simple dual-port memory with registered read data
module dq_mem
    import dq_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int AW = 3
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // array itself has no reset so it can map onto block ram
    always_ff @(posedge ref_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    // read port; old data wins on a same-address collision
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata <= '0;
        end
        else
        begin
            rdata <= mem[raddr];
        end
    end

endmodule : dq_mem

// ### design/dq_top.sv
`timescale 1ns/1ns
module dq_top
    import dq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic cfg_wr,
    input wire dq_cfg_t cfg_in,
    input wire logic [7:0] dio_i,
    output logic [7:0] dio_o,
    output logic [7:0] dio_oe,
    output logic [7:0] dio_in_val,
    input wire logic event_count_input,
    input wire logic ctr_clr,
    output logic [31:0] ctr_value,
    input wire logic sync_i,
    output logic sync_o,
    output logic sync_oe,
    output logic ext_overrun,
    input wire logic overrun_clr,
    input wire logic acquisition_trigger_input,
    input wire logic acq_arm,
    input wire logic acq_stop,
    output logic acq_busy,
    output logic acq_armed,
    input wire logic gq_wr,
    input wire logic [2:0] gq_widx,
    input wire dq_gq_t gq_wentry,
    output logic conv_start,
    output dq_gq_t conv_entry,
    input wire logic adc_valid,
    input wire logic signed [17:0] adc_sample,
    output logic res_valid,
    output logic [15:0] res_code,
    input wire logic buf_rd,
    output logic [15:0] buf_data,
    output logic buf_data_valid,
    output logic [15:0] buf_level,
    output logic buf_full
);

    // rising edge of a synchronised level
    function automatic logic rise_of(input logic prev, input logic cur);
        rise_of = cur & ~prev;
    endfunction : rise_of

    // offset binary with clamping at both ends
    function automatic logic [15:0] to_code(input logic signed [17:0] s);
        if (s > SAMPLE_MAX)
            to_code = CODE_FULL;
        else if (s < SAMPLE_MIN)
            to_code = CODE_ZERO;
        else
            to_code = {~s[15], s[14:0]};
    endfunction : to_code

    dq_state_t st_ff;
    dq_state_t nxt_st;
    logic [SY_W-1:0] sy;
    dq_gq_t gq_rdata;
    logic [15:0] buf_rdata;
    logic ev_rise;
    logic trig_hit;
    logic pace_rise;
    logic int_tick;
    logic conv_tick;
    logic buf_we;
    logic buf_pop;
    logic [15:0] pdiv_eff;

    dq_sync #(.WIDTH(SY_W)) u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .async_in({sync_i, acquisition_trigger_input,
                   event_count_input, dio_i}),
        .sync_out(sy)
    );

    // per-channel range table, one entry per queue slot
    dq_mem #(.WIDTH($bits(dq_gq_t)), .DEPTH(GQ_DEPTH), .AW(GQ_AW)) u_gq (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .we(gq_wr),
        .waddr(gq_widx),
        .wdata(gq_wentry),
        .raddr(nxt_st.gq_idx), // read ahead: no stale slot right after arm
        .rdata(gq_rdata)
    );

    // burst capture store
    dq_mem #(.WIDTH(16), .DEPTH(BUF_DEPTH), .AW(BUF_AW)) u_buf (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .we(buf_we),
        .waddr(st_ff.wr_ptr[BUF_AW-1:0]),
        .wdata(st_ff.res),
        .raddr(st_ff.rd_ptr[BUF_AW-1:0]),
        .rdata(buf_rdata)
    );

    // edge events and pacing sources
    always_comb
    begin
        ev_rise = rise_of(st_ff.prev_ev, sy[SY_EV]);
        trig_hit = st_ff.cfg.trig_rise ?
            rise_of(st_ff.prev_trig, sy[SY_TRIG]) :
            rise_of(sy[SY_TRIG], st_ff.prev_trig);
        // ignore our own pacer when the pin is being driven
        pace_rise = rise_of(st_ff.prev_pace, sy[SY_PACE]) &
            ~st_ff.cfg.pace_out;
        int_tick = (st_ff.pcnt == 16'h0000);
        conv_tick = st_ff.cfg.external_pacing_option ?
            pace_rise : int_tick;
        pdiv_eff = (st_ff.cfg.pdiv < PACER_DIV_MIN) ?
            PACER_DIV_MIN : st_ff.cfg.pdiv;
        buf_we = st_ff.res_v && st_ff.cfg.burst &&
            (st_ff.wr_ptr != BUF_FULL_LVL) && (st_ff.acq == ACQ_RUN);
        buf_pop = buf_rd && (st_ff.rd_ptr != st_ff.wr_ptr);
    end

    // next state of the whole block
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.prev_ev = sy[SY_EV];
        nxt_st.prev_trig = sy[SY_TRIG];
        nxt_st.prev_pace = sy[SY_PACE];
        nxt_st.conv = 1'b0;
        nxt_st.res_v = 1'b0;
        nxt_st.rd_v = 1'b0;
        if (cfg_wr)
        begin
            nxt_st.cfg = cfg_in;
        end
        // lines read back their pin when input, their driver when output
        nxt_st.din = (sy[7:0] & ~st_ff.cfg.dir) |
            (st_ff.cfg.dout & st_ff.cfg.dir);
        // clear and edge together still count the edge
        if (ctr_clr)
        begin
            nxt_st.ctr = 32'(ev_rise);
        end
        else if (ev_rise)
        begin
            nxt_st.ctr = st_ff.ctr + 32'h0000_0001;
        end
        // internal pacer: square wave, high in the first half of a period
        if (int_tick)
        begin
            nxt_st.pcnt = pdiv_eff - 16'h0001;
        end
        else
        begin
            nxt_st.pcnt = st_ff.pcnt - 16'h0001;
        end
        nxt_st.plvl = (nxt_st.pcnt >= {1'b0, pdiv_eff[15:1]});
        // too-fast external pace is flagged, never rejected
        if (pace_rise)
        begin
            nxt_st.gap = 11'h001; // the edge cycle itself counts as one
        end
        else if (st_ff.gap < EXT_PACE_MIN_CYC)
        begin
            nxt_st.gap = st_ff.gap + 11'h001;
        end
        if (pace_rise && st_ff.cfg.external_pacing_option &&
            (st_ff.gap < EXT_PACE_MIN_CYC))
        begin
            nxt_st.ovr = 1'b1;
        end
        else if (overrun_clr)
        begin
            nxt_st.ovr = 1'b0;
        end
        // acquisition sequencing
        case (st_ff.acq)
            ACQ_IDLE:
            begin
                if (acq_arm)
                begin
                    nxt_st.wr_ptr = 16'h0000;
                    nxt_st.rd_ptr = 16'h0000;
                    nxt_st.gq_idx = 3'h0;
                    nxt_st.acq = st_ff.cfg.trig_en ? ACQ_ARMED : ACQ_RUN;
                end
            end
            ACQ_ARMED:
            begin
                if (acq_stop)
                    nxt_st.acq = ACQ_IDLE;
                else if (trig_hit)
                    nxt_st.acq = ACQ_RUN;
            end
            ACQ_RUN:
            begin
                if (conv_tick)
                begin
                    nxt_st.conv = 1'b1;
                    nxt_st.conv_e = gq_rdata;
                    nxt_st.gq_idx = st_ff.gq_idx + 3'h1;
                end
                if (acq_stop ||
                    (st_ff.cfg.burst && nxt_st.wr_ptr == BUF_FULL_LVL))
                    nxt_st.acq = ACQ_IDLE;
            end
            default:
            begin
                nxt_st.acq = ACQ_IDLE;
            end
        endcase
        // converter results
        if (adc_valid)
        begin
            nxt_st.res_v = 1'b1;
            nxt_st.res = to_code(adc_sample);
        end
        if (buf_we)
        begin
            nxt_st.wr_ptr = st_ff.wr_ptr + 16'h0001;
        end
        if (buf_pop)
        begin
            nxt_st.rd_ptr = st_ff.rd_ptr + 16'h0001;
            nxt_st.rd_v = 1'b1;
        end
        // an arm taken in idle restarts the buffer, even mid-pop
        if (st_ff.acq == ACQ_IDLE && acq_arm)
        begin
            nxt_st.wr_ptr = 16'h0000;
            nxt_st.rd_ptr = 16'h0000;
        end
    end

    // state register; lines come up as inputs, pacing pin as input
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_ff <= '0;
            st_ff.cfg.dir <= DIR_RST;
            st_ff.cfg.dout <= DOUT_RST;
            st_ff.cfg.pace_out <= 1'b0;
            st_ff.cfg.pdiv <= PACER_DIV_RST;
            st_ff.acq <= ACQ_IDLE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // outputs
    assign dio_o = st_ff.cfg.dout;
    assign dio_oe = st_ff.cfg.dir;
    assign dio_in_val = st_ff.din;
    assign ctr_value = st_ff.ctr;
    assign sync_o = st_ff.plvl;
    assign sync_oe = st_ff.cfg.pace_out;
    assign ext_overrun = st_ff.ovr;
    assign acq_busy = (st_ff.acq == ACQ_RUN);
    assign acq_armed = (st_ff.acq == ACQ_ARMED);
    assign conv_start = st_ff.conv;
    assign conv_entry = st_ff.conv_e;
    assign res_valid = st_ff.res_v;
    assign res_code = st_ff.res;
    assign buf_data = buf_rdata;
    assign buf_data_valid = st_ff.rd_v;
    assign buf_level = st_ff.wr_ptr - st_ff.rd_ptr;
    assign buf_full = (st_ff.wr_ptr == BUF_FULL_LVL);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // direction follows the host write and lines start as inputs
    a_dio_dir_write: assert property (
        cfg_wr |=> dio_oe == $past(cfg_in.dir))
        else $error("line direction not taken from host write");
    a_dio_reset_in: assert property ($rose(nrst) |-> dio_oe == 8'h00)
        else $error("lines not inputs after reset");
    a_dio_read_val: assert property (
        ($stable(dio_i) && $stable(dio_oe))[*4] |->
        dio_in_val == ((dio_i & ~dio_oe) | (dio_o & dio_oe)))
        else $error("line readback wrong");

    // event counter
    a_ctr_pin_lat: assert property (
        $rose(event_count_input) |-> ##2 ev_rise)
        else $error("event edge not seen two cycles after pin");
    a_ctr_inc_one: assert property (ev_rise && !ctr_clr |=>
        ctr_value == $past(ctr_value) + 32'h0000_0001)
        else $error("counter did not advance by one");
    a_ctr_hold_fall: assert property (
        !ev_rise && !ctr_clr |=> $stable(ctr_value))
        else $error("counter moved without a rising edge");
    a_ctr_wrap_zero: assert property (ev_rise && !ctr_clr &&
        ctr_value == 32'hFFFF_FFFF |=> ctr_value == 32'h0000_0000)
        else $error("counter did not wrap to zero");

    // pacing pin
    a_pace_rst_in: assert property ($rose(nrst) |-> !sync_oe)
        else $error("pacing pin driven after reset");
    a_pace_drive: assert property (
        cfg_wr && cfg_in.pace_out |=> sync_oe)
        else $error("pacer not driven on pin");
    a_pace_wave: assert property (sync_oe && int_tick |=> sync_o)
        else $error("pacer period did not start high");
    a_ext_pace_conv: assert property (acq_busy && !acq_stop &&
        st_ff.cfg.external_pacing_option && pace_rise |=> conv_start)
        else $error("external edge did not pace a conversion");
    a_slave_no_int: assert property (
        st_ff.cfg.external_pacing_option && !pace_rise |=> !conv_start)
        else $error("slave converted without an external edge");

    // trigger and queue
    a_trig_start: assert property (
        acq_armed && !acq_stop && trig_hit |=> acq_busy)
        else $error("selected trigger edge did not start acquisition");
    a_gq_step: assert property (conv_start |->
        conv_entry == $past(gq_rdata) ##0
        st_ff.gq_idx == $past(st_ff.gq_idx) + 3'h1)
        else $error("gain entry not stepped per conversion");

    // result coding and burst capture
    a_code_mid: assert property (
        adc_valid && adc_sample == 18'sh00000 |=>
        res_valid && res_code == CODE_MID)
        else $error("zero input not mid-scale");
    a_code_sat: assert property (
        adc_valid && adc_sample > SAMPLE_MAX |=> res_code == CODE_FULL)
        else $error("over range did not saturate");
    a_burst_fill: assert property (
        buf_we && !(acq_arm && !acq_busy) |=>
        buf_full || buf_level != 16'h0000)
        else $error("burst sample not stored");

    c_ctr_wrap: cover property (ev_rise && ctr_value == 32'hFFFF_FFFF);
    c_trig_start: cover property (acq_armed ##1 acq_busy);
    c_ext_conv: cover property (st_ff.cfg.external_pacing_option && conv_start);
    c_burst_full: cover property ($rose(buf_full));

endmodule : dq_top

// ### bench/dq_far_model.sv
`timescale 1ns/1ns
// far side: converter front end plus a master unit on the pacing pin
module dq_far_model
    import dq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic conv_start,
    input wire logic slow,
    input wire logic pace_run,
    output logic adc_valid,
    output logic signed [17:0] adc_sample,
    output logic pace_line
);
    int wait_n;
    int kind;
    int pcnt;

    // answer each conversion after 1 or 6 cycles; samples walk through
    // mid-scale, both limits and both overranges, then a random value
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_n <= 0;
            kind <= 0;
            adc_valid <= 1'b0;
            adc_sample <= '0;
        end
        else
        begin
            adc_valid <= 1'b0;
            adc_sample <= ~adc_sample; // stale data never looks valid
            if (conv_start)
                wait_n <= slow ? 6 : 1;
            else if (wait_n > 0)
            begin
                wait_n <= wait_n - 1;
                if (wait_n == 1)
                begin
                    adc_valid <= 1'b1;
                    kind <= (kind + 1) % 6;
                    case (kind)
                        0: adc_sample <= 18'sh0_0000;
                        1: adc_sample <= 18'sh0_7fff;
                        2: adc_sample <= 18'sh0_8000;
                        3: adc_sample <= -18'sh0_8000;
                        4: adc_sample <= -18'sh0_8001;
                        default: adc_sample <= 18'($urandom);
                    endcase
                end
            end
        end
    end

    // master pacer: 500 cycles low, 500 high, i.e. the 50 kHz ceiling
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst || !pace_run)
        begin
            pcnt <= 0;
            pace_line <= 1'b0;
        end
        else
        begin
            pcnt <= (pcnt == 999) ? 0 : pcnt + 1;
            pace_line <= (pcnt >= 499) && (pcnt != 999);
        end
    end
endmodule : dq_far_model

// ### bench/test_daq_digital_io_sync_control.sv
`timescale 1ns/1ns
module test_daq_digital_io_sync_control;
    import dq_pkg::*;
    logic ref_clk, nrst, cfg_wr, ctr_clr, ev_in, sync_o, sync_oe, sync_i;
    logic ext_overrun, trig, acq_arm, acq_stop, acq_busy, acq_armed, gq_wr;
    logic conv_start, adc_valid, res_valid, buf_rd, buf_data_valid, buf_full;
    logic slow, pace_run, pace_line;
    logic [7:0] dio_i, dio_o, dio_oe, dio_in_val, ext_pins;
    logic [31:0] ctr_value;
    logic [2:0] gq_widx;
    logic signed [17:0] adc_sample;
    logic [15:0] res_code, buf_data, buf_level;
    dq_cfg_t cfg_in;
    dq_gq_t gq_wentry, conv_entry;
    dq_gq_t gq_m [8];
    logic [15:0] exp_q [$];
    logic [15:0] buf_q [$];
    int bad_count, tests_run, conv_cnt, res_cnt, conv_idx;
    bit burst_on;

    // pin levels from every party's enable
    assign dio_i = (dio_oe & dio_o) | (~dio_oe & ext_pins);
    assign sync_i = sync_oe ? sync_o : pace_line;

    dq_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .cfg_wr(cfg_wr),
        .cfg_in(cfg_in), .dio_i(dio_i), .dio_o(dio_o), .dio_oe(dio_oe),
        .dio_in_val(dio_in_val), .event_count_input(ev_in),
        .ctr_clr(ctr_clr), .ctr_value(ctr_value), .sync_i(sync_i),
        .sync_o(sync_o), .sync_oe(sync_oe), .ext_overrun(ext_overrun),
        .overrun_clr(1'b0), .acquisition_trigger_input(trig),
        .acq_arm(acq_arm), .acq_stop(acq_stop), .acq_busy(acq_busy),
        .acq_armed(acq_armed), .gq_wr(gq_wr), .gq_widx(gq_widx),
        .gq_wentry(gq_wentry), .conv_start(conv_start),
        .conv_entry(conv_entry), .adc_valid(adc_valid),
        .adc_sample(adc_sample), .res_valid(res_valid),
        .res_code(res_code), .buf_rd(buf_rd), .buf_data(buf_data),
        .buf_data_valid(buf_data_valid), .buf_level(buf_level),
        .buf_full(buf_full));

    dq_far_model far_u (.ref_clk(ref_clk), .nrst(nrst),
        .conv_start(conv_start), .slow(slow), .pace_run(pace_run),
        .adc_valid(adc_valid), .adc_sample(adc_sample),
        .pace_line(pace_line));

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task check(input bit ok, input string msg);
        tests_run++;
        if (!ok)
        begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check

    task stop_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    // offset binary with clipping instead of wrap
    function automatic logic [15:0] code_of(logic signed [17:0] s);
        if (s > 18'sh0_7fff)
            return 16'hffff;
        if (s < -18'sh0_8000)
            return 16'h0000;
        return 16'(s + 18'sh0_8000);
    endfunction : code_of

    task cfg_go(input dq_cfg_t c);
        @(posedge ref_clk);
        cfg_in <= c;
        cfg_wr <= 1'b1;
        @(posedge ref_clk);
        cfg_wr <= 1'b0;
    endtask : cfg_go

    // one-cycle strobe: 0 arm, 1 stop, 2 counter clear, 3 buffer pop
    task pulse(input int w);
        @(posedge ref_clk);
        if (w == 0)
            conv_idx = 0;
        case (w)
            0: acq_arm <= 1'b1;
            1: acq_stop <= 1'b1;
            2: ctr_clr <= 1'b1;
            default: buf_rd <= 1'b1;
        endcase
        @(posedge ref_clk);
        {acq_arm, acq_stop, ctr_clr, buf_rd} <= 4'h0;
    endtask : pulse

    // every entry covers a distinct channel and ranges repeat all four codes
    task gq_load;
        int k;
        k = $urandom % 8;
        for (int i = 0; i < 8; i++)
        begin
            gq_m[i].chan = 3'((i + k) % 8);
            gq_m[i].range = dq_range_t'(2'(i + k));
            @(posedge ref_clk);
            gq_wr <= 1'b1;
            gq_widx <= 3'(i);
            gq_wentry <= gq_m[i];
        end
        @(posedge ref_clk);
        gq_wr <= 1'b0;
    endtask : gq_load

    // reference model: results in order, entries in slot order
    always @(posedge ref_clk)
    begin
        if (res_valid)
        begin
            res_cnt++;
            check(exp_q.size() > 0 && res_code === exp_q[0], "code");
            if (burst_on && exp_q.size() > 0)
                buf_q.push_back(exp_q[0]);
            if (exp_q.size() > 0)
                void'(exp_q.pop_front());
        end
        if (adc_valid)
            exp_q.push_back(code_of(adc_sample));
        if (conv_start)
        begin
            check(conv_entry === gq_m[conv_idx], "entry");
            conv_idx = (conv_idx + 1) % 8;
            conv_cnt++;
        end
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test;
    end

    initial
    begin
        dq_cfg_t c;
        int k;
        nrst = 1'b0;
        {cfg_wr, ctr_clr, ev_in, trig, acq_arm, acq_stop, gq_wr} = 7'h00;
        {buf_rd, slow, pace_run, burst_on} = 4'h0;
        cfg_in = '0;
        ext_pins = 8'h00;
        gq_widx = 3'h0;
        gq_wentry = '0;
        void'($urandom(32'h977e_d88a));
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        @(negedge ref_clk);
        check(dio_oe === 8'h00 && ctr_value === 32'h0000_0000, "rst");
        check(sync_oe === 1'b0, "pacing pin direction");
        $display("test reset finished");
        for (int i = 0; i < 6; i++)
        begin
            c = '0;
            c.pdiv = 16'h03e8;
            c.dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            c.dout = 8'($urandom);
            cfg_go(c);
            ext_pins <= 8'($urandom);
            repeat (4) @(posedge ref_clk);
            @(negedge ref_clk);
            check(dio_oe === c.dir && dio_o === c.dout, "direction");
            k = 0;
            check(dio_in_val === ((c.dir & c.dout) |
                (~c.dir & ext_pins)), "line level");
        end
        $display("test lines finished");
        pulse(2);
        for (k = 0; k < 10; k++)
        begin
            @(posedge ref_clk);
            ev_in <= 1'b1;
            repeat (25) @(posedge ref_clk);
            ev_in <= 1'b0;
            repeat (24) @(posedge ref_clk);
        end
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        check(ctr_value === 32'h0000_000a, "event count");
        pulse(2);
        @(negedge ref_clk);
        check(ctr_value === 32'h0000_0000, "counter clear");
        $display("test counter finished");
        gq_load;
        c = '0;
        c.pdiv = 16'h0014;
        c.burst = 1'b1;
        cfg_go(c);
        burst_on = 1'b1;
        res_cnt = 0;
        pulse(0);
        for (k = 0; k < 2000 && res_cnt < 12; k++)
        begin
            @(posedge ref_clk);
            slow <= (res_cnt >= 6);
        end
        pulse(1);
        burst_on = 1'b0;
        check(res_cnt == 12, "result count");
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check(acq_busy === 1'b0 && buf_full === 1'b0 &&
            buf_level === 16'(buf_q.size()), "burst level");
        while (buf_q.size() > 0)
        begin
            pulse(3);
            @(negedge ref_clk);
            check(buf_data_valid === 1'b1 &&
                buf_data === buf_q.pop_front(), "fifo order");
        end
        pulse(3);
        @(negedge ref_clk);
        check(buf_data_valid === 1'b0 && buf_level === 16'h0000, "pop");
        $display("test burst finished");
        for (int r = 1; r >= 0; r--)
        begin
            c = '0;
            c.pdiv = 16'h0014;
            c.trig_en = 1'b1;
            c.trig_rise = 1'(r);
            cfg_go(c);
            trig <= 1'(r);
            repeat (4) @(posedge ref_clk);
            pulse(0);
            trig <= ~1'(r);
            repeat (6) @(posedge ref_clk);
            @(negedge ref_clk);
            check(acq_armed === 1'b1 && acq_busy === 1'b0, "wrong edge");
            trig <= 1'(r);
            repeat (5) @(posedge ref_clk);
            @(negedge ref_clk);
            check(acq_busy === 1'b1, "trigger start");
            pulse(1);
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            check(acq_busy === 1'b0 && acq_armed === 1'b0, "stop");
        end
        $display("test trigger finished");
        c = '0;
        c.pdiv = 16'h000a;
        c.pace_out = 1'b1;
        cfg_go(c);
        @(negedge ref_clk);
        check(sync_oe === 1'b1, "pacer output enable");
        repeat (20) @(posedge ref_clk);
        k = 0;
        repeat (100)
        begin
            @(posedge ref_clk);
            if (sync_o === 1'b1)
                k++;
        end
        check(k == 50, "pacer waveform");
        $display("test pacer output finished");
        // the source runs before the option is enabled, never the reverse
        pace_run <= 1'b1;
        slow <= 1'b1;
        c = '0;
        c.pdiv = 16'hffff;
        cfg_go(c);
        // edges left in the pin synchroniser must age out before listening
        repeat (1000) @(posedge ref_clk);
        c.external_pacing_option = 1'b1;
        cfg_go(c);
        conv_cnt = 0;
        pulse(0);
        repeat (3000) @(posedge ref_clk);
        check(conv_cnt == 3 && ext_overrun === 1'b0, "ext pacing");
        pulse(1);
        pace_run <= 1'b0;
        $display("test external pacing finished");
        stop_test;
    end
endmodule : test_daq_digital_io_sync_control
